/* File: pkg/urm_pkg.sv */
// constants and types for the user register space access policy
package urm_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  USER_LAST_ADDR  = 8'h98;
    localparam logic [7:0]  RSV_ADDR_A      = 8'h2C;
    localparam logic [7:0]  RSV_ADDR_B      = 8'h2D;
    localparam logic [7:0]  RSV_ADDR_C      = 8'h2E;
    localparam logic [7:0]  RSV_ADDR_D      = 8'h2F;
    localparam logic [7:0]  RSV_ADDR_E      = 8'h46;
    localparam logic [7:0]  CFG_ONE_ADDR    = 8'h10;
    localparam logic [7:0]  CFG_TWO_ADDR    = 8'h11;
    localparam logic [7:0]  STAT_ONE_ADDR   = 8'h02;
    localparam logic [7:0]  STAT_TWO_ADDR   = 8'h03;
    localparam int          CFG_ONE_SP_LSB  = 12;
    localparam int          CFG_ONE_SP_W    = 4;
    localparam int          CFG_TWO_SP_LSB  = 11;
    localparam int          CFG_TWO_SP_W    = 5;
    localparam int          STAT_ONE_PROTO  = 5;
    localparam int          STAT_TWO_RJCT   = 0;
    localparam logic [15:0] RESET_WORD      = 16'h0000;
    localparam logic [15:0] DEFAULT_MASK    = 16'hFFFF;
    localparam logic [15:0] STAT_ONE_MASK   = 16'h0020;
    localparam logic [15:0] STAT_TWO_MASK   = 16'h0001;
    typedef enum logic [1:0] {
        URM_IDLE_type_s = 2'b00,
        URM_READ_type_s = 2'b01,
        URM_BLOCK_type_s = 2'b11
    } urm_state_type;
endpackage

/* File: hdl/urm_mem.sv */
// word memory for the user register space with registered read data
`timescale 1ns/1ps
module urm_mem #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

    always_ff @(posedge mclk) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= store[raddr];
    end
endmodule

/* File: hdl/urm_access.sv */
// access policy for the user register space
// Function
// RULE1: accept access only with clean protocol; violations reject and raise status alerts
// RULE2: protocol-error transactions rejected outright, reserved handling skipped
// RULE3: user registers decoded only in 0x00..0x98; undefined ones reserved
// RULE4: addresses 0x2C..0x2F and 0x46 are reserved
// RULE5: addresses 0x99..0xFF are reserved
// RULE6: valid reserved access raises no error or alert
// RULE7: reserved writes discarded; reserved reads return zero
// RULE8: block readback returns every address, reserved ones as zero
// RULE9: PEC and CRC cover all 16 data bits including unused ones
// RULE10: unused bits ignore writes and read as zero
// RULE11: spare fields of 4 bits and 5 bits in the two configs
// RULE12: spare fields store and read back, steer nothing
// RULE13: host should avoid writing reserved addresses
// RULE14: reserved writes change no register and no flag
`timescale 1ns/1ps
module urm_access #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [ADDR_W-1:0] req_count,
    input  wire logic              proto_err,
    input  wire logic              alert_clear,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_data,
    output logic                   rsp_last,
    output logic                   rejected,
    output logic      [DATA_W-1:0] first_alert_status_reg,
    output logic      [DATA_W-1:0] second_alert_status_reg,
    output logic      [3:0]        cfg_one_spare_field,
    output logic      [4:0]        cfg_two_spare_field
);
    // ==========================================================
    // address decode helpers
    function automatic logic is_reserved(input logic [ADDR_W-1:0] a);
        return (a > urm_pkg::USER_LAST_ADDR) ||
               (a >= urm_pkg::RSV_ADDR_A && a <= urm_pkg::RSV_ADDR_D) ||
               (a == urm_pkg::RSV_ADDR_E);
    endfunction

    function automatic logic [DATA_W-1:0] used_mask(input logic [ADDR_W-1:0] a);
        case (a)
            urm_pkg::STAT_ONE_ADDR: used_mask = urm_pkg::STAT_ONE_MASK;
            urm_pkg::STAT_TWO_ADDR: used_mask = urm_pkg::STAT_TWO_MASK;
            default:                used_mask = urm_pkg::DEFAULT_MASK;
        endcase
    endfunction

    // ==========================================================
    // state
    urm_pkg::urm_state_type state;
    urm_pkg::urm_state_type next_state;
    logic [ADDR_W-1:0]      cur_addr;
    logic [ADDR_W-1:0]      next_cur_addr;
    logic [ADDR_W-1:0]      remain;
    logic [ADDR_W-1:0]      next_remain;
    logic                   pend_rsv;
    logic                   next_pend_rsv;
    logic                   proto_flag;
    logic                   next_proto_flag;
    logic                   rjct_flag;
    logic                   next_rjct_flag;
    logic                   next_rejected;
    logic [3:0]             next_cfg_one;
    logic [4:0]             next_cfg_two;
    logic                   mem_we;
    logic [DATA_W-1:0]      mem_rdata;
    logic [ADDR_W-1:0]      mem_raddr;
    logic                   accept;
    logic                   last_word;

    urm_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) urm_mem_inst (
        .mclk  (mclk),
        .we    (mem_we),
        .waddr (req_addr),
        .wdata (req_wdata & used_mask(req_addr)),          // [RULE10]
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ==========================================================
    // sequencing
    always_comb begin
        req_ready       = (state == urm_pkg::URM_IDLE_type_s);
        accept          = req_ready && req_valid && !proto_err;   // [RULE1] [RULE2]
        next_state      = state;
        next_cur_addr   = cur_addr;
        next_remain     = remain;
        next_pend_rsv   = pend_rsv;
        next_proto_flag = proto_flag && !alert_clear;
        next_rjct_flag  = rjct_flag && !alert_clear;
        next_rejected   = 1'b0;
        next_cfg_one    = cfg_one_spare_field;
        next_cfg_two    = cfg_two_spare_field;
        mem_we          = 1'b0;
        mem_raddr       = req_addr;
        last_word       = (remain == '0);
        if (req_ready && req_valid && proto_err) begin            // [RULE9]
            next_proto_flag = 1'b1;                               // [RULE1]
            next_rjct_flag  = 1'b1;                               // [RULE1]
            next_rejected   = 1'b1;                               // [RULE2]
        end
        case (state)
            urm_pkg::URM_IDLE_type_s: begin
                if (accept && req_write) begin
                    // reserved writes dropped, no flag touched [RULE7] [RULE14] [RULE6]
                    mem_we = !is_reserved(req_addr);              // [RULE3] [RULE4] [RULE5]
                    if (req_addr == urm_pkg::CFG_ONE_ADDR) begin
                        next_cfg_one = req_wdata[urm_pkg::CFG_ONE_SP_LSB +: 4]; // [RULE11]
                    end
                    if (req_addr == urm_pkg::CFG_TWO_ADDR) begin
                        next_cfg_two = req_wdata[urm_pkg::CFG_TWO_SP_LSB +: 5]; // [RULE11]
                    end
                end else if (accept) begin
                    next_cur_addr = req_addr;
                    next_remain   = req_count;
                    next_pend_rsv = is_reserved(req_addr);
                    next_state    = urm_pkg::URM_READ_type_s;
                end
            end
            urm_pkg::URM_READ_type_s: begin
                mem_raddr = cur_addr;
                if (last_word) begin
                    next_state = urm_pkg::URM_IDLE_type_s;
                end else begin
                    next_cur_addr = ADDR_W'(cur_addr + 1'b1);     // [RULE8]
                    next_remain   = ADDR_W'(remain - 1'b1);
                    next_pend_rsv = is_reserved(ADDR_W'(cur_addr + 1'b1));
                    mem_raddr     = ADDR_W'(cur_addr + 1'b1);
                    next_state    = urm_pkg::URM_BLOCK_type_s;
                end
            end
            urm_pkg::URM_BLOCK_type_s: begin
                mem_raddr = cur_addr;
                if (last_word) begin
                    next_state = urm_pkg::URM_IDLE_type_s;
                end else begin
                    next_cur_addr = ADDR_W'(cur_addr + 1'b1);     // [RULE8]
                    next_remain   = ADDR_W'(remain - 1'b1);
                    next_pend_rsv = is_reserved(ADDR_W'(cur_addr + 1'b1));
                    mem_raddr     = ADDR_W'(cur_addr + 1'b1);
                end
            end
            default: begin
                next_state = urm_pkg::URM_IDLE_type_s;
            end
        endcase
    end

    // ==========================================================
    // read data path
    logic [DATA_W-1:0] stat_one_word;
    logic [DATA_W-1:0] stat_two_word;

    always_comb begin
        stat_one_word = '0;
        stat_two_word = '0;
        stat_one_word[urm_pkg::STAT_ONE_PROTO] = proto_flag;
        stat_two_word[urm_pkg::STAT_TWO_RJCT]  = rjct_flag;
        rsp_valid = (state != urm_pkg::URM_IDLE_type_s);
        rsp_last  = rsp_valid && last_word;
        if (!rsp_valid || pend_rsv) begin
            rsp_data = '0;                                        // [RULE7] [RULE8]
        end else if (cur_addr == urm_pkg::STAT_ONE_ADDR) begin
            rsp_data = stat_one_word;
        end else if (cur_addr == urm_pkg::STAT_TWO_ADDR) begin
            rsp_data = stat_two_word;
        end else if (cur_addr == urm_pkg::CFG_ONE_ADDR) begin
            rsp_data = {cfg_one_spare_field, 12'h000};            // [RULE12]
        end else if (cur_addr == urm_pkg::CFG_TWO_ADDR) begin
            rsp_data = {cfg_two_spare_field, 11'h000};            // [RULE12]
        end else begin
            rsp_data = mem_rdata;
        end
    end

    assign first_alert_status_reg  = stat_one_word;
    assign second_alert_status_reg = stat_two_word;

    // ==========================================================
    // registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state               <= urm_pkg::URM_IDLE_type_s;
            cur_addr            <= '0;
            remain              <= '0;
            pend_rsv            <= 1'b0;
            proto_flag          <= 1'b0;
            rjct_flag           <= 1'b0;
            rejected            <= 1'b0;
            cfg_one_spare_field <= 4'h0;
            cfg_two_spare_field <= 5'h00;
        end else begin
            state               <= next_state;
            cur_addr            <= next_cur_addr;
            remain              <= next_remain;
            pend_rsv            <= next_pend_rsv;
            proto_flag          <= next_proto_flag;
            rjct_flag           <= next_rjct_flag;
            rejected            <= next_rejected;
            cfg_one_spare_field <= next_cfg_one;
            cfg_two_spare_field <= next_cfg_two;
        end
    end
endmodule

/* File: testbench/urm_access_properties.sv */
// concurrent checks on the access policy ports
`timescale 1ns/1ps
module urm_access_properties (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [7:0]  req_addr,
    input wire logic [7:0]  req_count,
    input wire logic        proto_err,
    input wire logic        alert_clear,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic        rsp_last,
    input wire logic        rejected,
    input wire logic [15:0] first_alert_status_reg,
    input wire logic [15:0] second_alert_status_reg
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // =========================================
    // request decode
    logic take, bad, ok, rsv;
    assign take = req_valid && req_ready;
    assign bad  = take && proto_err;
    assign ok   = take && !proto_err;
    assign rsv  = req_addr > urm_pkg::USER_LAST_ADDR || req_addr == urm_pkg::RSV_ADDR_E
                  || (req_addr >= urm_pkg::RSV_ADDR_A && req_addr <= urm_pkg::RSV_ADDR_D);
    sequence s_rsv_read;
        ok && !req_write && rsv && req_count == 8'h00;
    endsequence
    sequence s_pair_read;
        ok && !req_write && req_count == 8'h01;
    endsequence
    sequence s_walk_answer;
        rsp_valid && !rsp_last ##1 rsp_valid && rsp_last ##1 req_ready;
    endsequence
    // =========================================
    // properties
    a_reject_pulse: assert property (bad |=> rejected) else $error("no reject pulse");
    a_clean_taken: assert property (ok |=> !rejected)
        else $error("clean request refused");
    a_alert_set: assert property (bad |=> first_alert_status_reg[5]
        && second_alert_status_reg[0]) else $error("alerts not raised");
    a_error_no_data: assert property (bad |=> !rsp_valid)
        else $error("refused read answered");
    a_rsv_zero: assert property (s_rsv_read |=> rsp_valid && rsp_last
        && rsp_data == 16'h0000) else $error("reserved read not zero");
    a_block_walk: assert property (s_pair_read |=> s_walk_answer)
        else $error("block walk wrong");
    a_unused_zero: assert property (
        ((first_alert_status_reg & ~urm_pkg::STAT_ONE_MASK) == 16'h0000)
        && ((second_alert_status_reg & ~urm_pkg::STAT_TWO_MASK) == 16'h0000))
        else $error("unused status bits set");
    a_flag_hold: assert property (first_alert_status_reg[5] && !alert_clear
        |=> $stable(first_alert_status_reg)) else $error("alert flag dropped");
    a_flag_clear: assert property (alert_clear && !take
        |=> second_alert_status_reg == 16'h0000) else $error("alert flag not cleared");
    a_rsv_quiet: assert property (ok && rsv && !first_alert_status_reg[5]
        |=> !first_alert_status_reg[5]) else $error("reserved access alerted");
endmodule

bind urm_access urm_access_properties urm_access_properties_inst (
    .mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_count(req_count), .proto_err(proto_err), .alert_clear(alert_clear),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
    .rejected(rejected), .first_alert_status_reg(first_alert_status_reg),
    .second_alert_status_reg(second_alert_status_reg)
);

/* File: testbench/urm_host_model.sv */
// host side model issuing link requests and gathering answer words
`timescale 1ns/1ps
module urm_host_model (
    input  wire logic        mclk,
    input  wire logic        req_ready,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_data,
    input  wire logic        rejected,
    output logic             req_valid = 1'b0,
    output logic             req_write = 1'b0,
    output logic      [7:0]  req_addr = 8'h00,
    output logic      [15:0] req_wdata = 16'h0000,
    output logic      [7:0]  req_count = 8'h00,
    output logic             proto_err = 1'b0
);
    logic [16:0] words [$];
    logic        rej;
    // reserved writes only when the bench asks for them
    task automatic send(input logic w, input logic [7:0] a, input logic [15:0] d,
                        input logic [7:0] c, input logic e);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d; // full 16-bit word, checked upstream
        req_count <= c;
        proto_err <= e;
        @(negedge mclk);
        while (req_ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        req_valid <= 1'b0;
        req_write <= ~w;
        req_addr  <= ~a;
        req_wdata <= ~d;
        req_count <= ~c;
        proto_err <= ~e;
        words = {};
        @(negedge mclk);
        rej = rejected;
        for (int i = 0; !w && i <= int'(c); i++) begin
            if (i > 0) @(negedge mclk);
            words.push_back({rsp_valid, rsp_data});
        end
    endtask
endmodule

/* File: testbench/urm_access_test.sv */
// self-checking bench for the user register space access policy
`timescale 1ns/1ps
module urm_access_test;
    logic        mclk, sys_rst, alert_clear, req_valid, req_write, proto_err;
    logic        req_ready, rsp_valid, rsp_last, rejected;
    logic [7:0]  req_addr, req_count;
    logic [15:0] req_wdata, rsp_data, first_alert_status_reg, second_alert_status_reg;
    logic [3:0]  cfg_one_spare_field;
    logic [4:0]  cfg_two_spare_field;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [7:0]  rsv_list [7] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h46, 8'h99, 8'hFF};
    urm_access urm_access_inst (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_count(req_count),
        .proto_err(proto_err), .alert_clear(alert_clear), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rejected(rejected),
        .first_alert_status_reg(first_alert_status_reg),
        .second_alert_status_reg(second_alert_status_reg),
        .cfg_one_spare_field(cfg_one_spare_field), .cfg_two_spare_field(cfg_two_spare_field));
    urm_host_model urm_host_model_inst (.mclk(mclk), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rejected(rejected), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_count(req_count), .proto_err(proto_err));
    // =========================================
    // shared helpers
    task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        urm_host_model_inst.send(1'b1, a, d, 8'h00, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] d);
        urm_host_model_inst.send(1'b0, a, 16'h0000, 8'h00, 1'b0);
        check("read word", {1'b1, d}, urm_host_model_inst.words[0]);
    endtask
    // =========================================
    // scenarios
    task automatic t_reserved;
        wr(8'h20, 16'hA5A5);
        wr(urm_pkg::USER_LAST_ADDR, 16'h5A5A);
        foreach (rsv_list[i]) begin
            wr(rsv_list[i], 16'hBEEF);
            check("reject pulse", 17'h0, {16'h0, urm_host_model_inst.rej});
            rd(rsv_list[i], 16'h0000);
        end
        rd(8'h20, 16'hA5A5);
        rd(urm_pkg::USER_LAST_ADDR, 16'h5A5A);
        check("alerts", 17'h0,
              {1'b0, first_alert_status_reg | second_alert_status_reg});
    endtask
    task automatic t_block;
        wr(8'h2B, 16'h1111);
        wr(8'h30, 16'h2222);
        urm_host_model_inst.send(1'b0, 8'h2B, 16'h0000, 8'h05, 1'b0);
        for (int i = 0; i < 6; i++)
            check("block word", {1'b1, i == 0 ? 16'h1111 : i == 5 ? 16'h2222 : 16'h0000},
                  urm_host_model_inst.words[i]);
        urm_host_model_inst.send(1'b0, 8'h2F, 16'h0000, 8'h01, 1'b0);
        check("pair word", {1'b1, 16'h2222}, urm_host_model_inst.words[1]);
    endtask
    task automatic t_spare;
        wr(urm_pkg::CFG_ONE_ADDR, 16'hA000);
        wr(urm_pkg::CFG_TWO_ADDR, 16'hB800);
        check("spare one", 17'h0000A, {13'h0, cfg_one_spare_field});
        check("spare two", 17'h00017, {12'h0, cfg_two_spare_field});
        rd(urm_pkg::CFG_ONE_ADDR, 16'hA000);
        rd(urm_pkg::CFG_TWO_ADDR, 16'hB800);
    endtask
    task automatic t_proto;
        urm_host_model_inst.send(1'b1, 8'h20, 16'h1234, 8'h00, 1'b1);
        check("reject pulse", 17'h1, {16'h0, urm_host_model_inst.rej});
        check("alert one", {1'b0, urm_pkg::STAT_ONE_MASK},
              {1'b0, first_alert_status_reg});
        check("alert two", {1'b0, urm_pkg::STAT_TWO_MASK},
              {1'b0, second_alert_status_reg});
        wr(urm_pkg::STAT_ONE_ADDR, 16'hFFFF);
        rd(urm_pkg::STAT_ONE_ADDR, urm_pkg::STAT_ONE_MASK);
        rd(urm_pkg::STAT_TWO_ADDR, urm_pkg::STAT_TWO_MASK);
        urm_host_model_inst.send(1'b1, 8'h2C, 16'h1234, 8'h00, 1'b1);
        check("reject pulse", 17'h1, {16'h0, urm_host_model_inst.rej});
        urm_host_model_inst.send(1'b0, 8'h46, 16'h0000, 8'h00, 1'b1);
        check("refused read", 17'h0, urm_host_model_inst.words[0]);
        rd(8'h20, 16'hA5A5);
        @(posedge mclk);
        alert_clear <= 1'b1;
        @(posedge mclk);
        alert_clear <= 1'b0;
        @(negedge mclk);
        check("cleared", 17'h0,
              {1'b0, first_alert_status_reg | second_alert_status_reg});
        rd(urm_pkg::STAT_ONE_ADDR, 16'h0000);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // =========================================
    // clock, reset, sequence, watchdog
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        sys_rst = 1'b1;
        alert_clear = 1'b0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reserved;
        t_block;
        t_spare;
        t_proto;
        report_and_stop;
    end
    initial begin
        #100000;
        n_errors++;
        report_and_stop;
    end
endmodule
